// ==== hs_status_params.svh ====
`ifndef HS_STATUS_PARAMS_SVH
`define HS_STATUS_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_STATE_WORD     8'h00
`define IDX_CNT_IRQ_CLR    8'h0A
`define IDX_TC1_CLR        8'h0C
`define IDX_TC2_CLR        8'h0E
`define IDX_CONTROL        8'h10
`define IDX_IRQ_STATUS     8'h11
`define IDX_IRQ_MASK       8'h12

// index taken from the byte address
`define IDX_LSB            2
`define IDX_MSB            9

// ahb-lite transfer type bit that marks nonseq or seq
`define HTRANS_ACTIVE_BIT  1

// status word field positions
`define BIT_ACTIVE_CHAN    15
`define BIT_CNT_IRQ        14
`define BIT_SPARE_HI       13
`define BIT_WIDE           12
`define BIT_EXTRA_ONE      11
`define BIT_TC2            10
`define BIT_TC1            9
`define BIT_G1_READY       8
`define BIT_G1_REQ         7
`define BIT_G1_ACK         6
`define BIT_EXTRA_TWO      5
`define BIT_REVISION       4
`define BIT_SPARE_LO       3
`define BIT_G2_READY       2
`define BIT_G2_REQ         1
`define BIT_G2_ACK         0

// reset values
`define CONTROL_RESET      9'h000
`define IRQ_BITS_RESET     3'h0
`define PINS_RESET         7'h7F
`define WORD_ZERO          32'h0000_0000
`define STATUS_ZERO        16'h0000

`endif

// ==== hs_status_pkg.sv ====
package hs_status_pkg;

   // software control word
   typedef struct packed {
      logic g2_handshake_en;   // group 2 handshake enabled
      logic g2_write_mode;     // group 2 drives the connector
      logic g1_handshake_en;   // group 1 handshake enabled
      logic g1_write_mode;     // group 1 drives the connector
      logic counter_two_enable;
      logic counter_one_enable;
      logic g2_wide;           // group 2 set for 32-bit transfers
      logic g1_wide;           // group 1 set for 32-bit transfers
      logic double_dma_mode;
   } ctrl_t;

   // sticky event flags, also the layout of the mask
   typedef struct packed {
      logic tc2;               // group 2 terminal count
      logic tc1;               // group 1 terminal count
      logic counter;           // counter 3 rising edge
   } irq_bits_t;

   // connector pins that cross into the bus clock
   typedef struct packed {
      logic cnt3_out;
      logic extra_input_two;
      logic extra_input_one;
      logic group2_acknowledge_line;
      logic group2_request_line;
      logic group1_acknowledge_line;
      logic group1_request_line;
   } conn_pins_t;

   // whole state of the block
   typedef struct packed {
      ctrl_t       ctrl;
      irq_bits_t   flags;
      irq_bits_t   mask;
      conn_pins_t  pin_meta;
      conn_pins_t  pin_sync;
      logic        cnt3_prev;
      logic        active_dma_channel;
      logic        wr_pend;
      logic [7:0]  wr_idx;
      logic [31:0] rdata;
      logic        irq;
      logic        counter_one_gate;
      logic        counter_two_gate;
   } state_t;

endpackage : hs_status_pkg

// ==== handshake_status_irq_clear.sv ====
// How it works
// - read-only 16-bit state word at index 0x00
// - bit 15 shows active dma channel
// - double mode alternates group 1 channels
// - bit 14 sets on enabled counter 3 rise
// - bit 12 set when both groups wide
// - bit 11 extra input one, gates counter one
// - bit 5 extra input two, gates counter two
// - bit 10 latches group 2 terminal count
// - bit 9 latches group 1 terminal count
// - bit 8 group 1 ready by mode
// - bit 2 group 2 ready by mode
// - bits 7,6 group 1 request, acknowledge live
// - bits 1,0 group 2 request, acknowledge live
// - write to 0x0A clears counter flag
// - write to 0x0C clears group 1 flag
// - write to 0x0E clears group 2 flag
//
// Implementation choice: the AHB-Lite slave port.
`include "hs_status_params.svh"

module handshake_status_irq_clear
   import hs_status_pkg::*;
#(
   // arbitrary value of the revision identifier bit
   parameter logic REVISION_ID = 1'b1
) (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // connector pins, asynchronous
   input  wire conn_pins_t  conn_pins,
   // dma engine events, same clock, one-cycle pulses
   input  wire logic        group1_terminal_count,
   input  wire logic        group2_terminal_count,
   input  wire logic        group1_dma_done,
   // outputs to counters, dma engine and interrupt controller
   output logic             counter_one_gate,
   output logic             counter_two_gate,
   output logic             active_dma_channel,
   output logic             irq
);

   state_t      st;           // registered state
   state_t      next_st;      // next state
   logic [15:0] status;       // assembled state word
   logic        addr_valid;   // address phase accepted this edge
   logic [7:0]  addr_idx;     // register index of the address phase
   logic        cnt3_rise;    // counter 3 rising edge seen
   logic        clr_cnt;      // write to counter clear register
   logic        clr_tc1;      // write to group 1 clear register
   logic        clr_tc2;      // write to group 2 clear register
   logic [2:0]  w1c;          // one-to-clear pattern for irq status

   // size is not checked: every width of write counts as a strobe
   logic        unused_size;
   assign unused_size = ^hsize;

   // bus decode and strobes from the pending write
   always_comb begin
      addr_valid = hsel && htrans[`HTRANS_ACTIVE_BIT] && hready;
      addr_idx   = haddr[`IDX_MSB:`IDX_LSB];
      cnt3_rise  = st.pin_sync.cnt3_out && !st.cnt3_prev;
      clr_cnt    = st.wr_pend && (st.wr_idx == `IDX_CNT_IRQ_CLR);
      clr_tc1    = st.wr_pend && (st.wr_idx == `IDX_TC1_CLR);
      clr_tc2    = st.wr_pend && (st.wr_idx == `IDX_TC2_CLR);
      if (st.wr_pend && (st.wr_idx == `IDX_IRQ_STATUS)) begin
         w1c = hwdata[2:0];
      end else begin
         w1c = `IRQ_BITS_RESET;
      end
   end

   // state word assembly, live from the synchronised pins
   always_comb begin
      status = `STATUS_ZERO;
      status[`BIT_ACTIVE_CHAN] = st.active_dma_channel;
      status[`BIT_CNT_IRQ]     = st.flags.counter;
      status[`BIT_SPARE_HI]    = 1'b0;
      status[`BIT_SPARE_LO]    = 1'b0;
      status[`BIT_WIDE]        = st.ctrl.g1_wide && st.ctrl.g2_wide;
      status[`BIT_EXTRA_ONE]   = st.pin_sync.extra_input_one;
      status[`BIT_TC2]         = st.flags.tc2;
      status[`BIT_TC1]         = st.flags.tc1;
      status[`BIT_G1_READY]    = st.pin_sync.group1_request_line &&
                                 (st.ctrl.g1_write_mode || st.ctrl.g1_handshake_en);
      status[`BIT_G1_REQ]      = st.pin_sync.group1_request_line;
      status[`BIT_G1_ACK]      = st.pin_sync.group1_acknowledge_line;
      status[`BIT_EXTRA_TWO]   = st.pin_sync.extra_input_two;
      status[`BIT_REVISION]    = REVISION_ID;
      status[`BIT_G2_READY]    = st.pin_sync.group2_request_line &&
                                 (st.ctrl.g2_write_mode || st.ctrl.g2_handshake_en);
      status[`BIT_G2_REQ]      = st.pin_sync.group2_request_line;
      status[`BIT_G2_ACK]      = st.pin_sync.group2_acknowledge_line;
   end

   // next state of the whole block
   always_comb begin
      next_st = st;

      // two-flop synchroniser; only the second stage is read elsewhere
      next_st.pin_meta  = conn_pins;
      next_st.pin_sync  = st.pin_meta;
      next_st.cnt3_prev = st.pin_sync.cnt3_out;

      // data phase write lands in the registers
      if (st.wr_pend && (st.wr_idx == `IDX_CONTROL)) begin
         next_st.ctrl = ctrl_t'(hwdata[8:0]);
      end
      if (st.wr_pend && (st.wr_idx == `IDX_IRQ_MASK)) begin
         next_st.mask = irq_bits_t'(hwdata[2:0]);
      end

      // sticky flags: a set in the clearing cycle wins
      // enabled rising edge sets
      next_st.flags.counter = (st.flags.counter && !clr_cnt && !w1c[0]) ||
                              (cnt3_rise && st.mask.counter);
      next_st.flags.tc1     = (st.flags.tc1 && !clr_tc1 && !w1c[1]) ||
                              group1_terminal_count;
      next_st.flags.tc2     = (st.flags.tc2 && !clr_tc2 && !w1c[2]) ||
                              group2_terminal_count;

      if (!st.ctrl.double_dma_mode) begin
         next_st.active_dma_channel = 1'b0;
      end else if (group1_dma_done) begin
         next_st.active_dma_channel = !st.active_dma_channel;
      end

      next_st.counter_one_gate = st.ctrl.counter_one_enable && st.pin_sync.extra_input_one;
      next_st.counter_two_gate = st.ctrl.counter_two_enable && st.pin_sync.extra_input_two;

      next_st.irq = |(next_st.flags & next_st.mask);

      // address phase: reads are answered in the following data phase
      next_st.wr_pend = addr_valid && hwrite;
      next_st.wr_idx  = addr_idx;
      next_st.rdata   = `WORD_ZERO;
      if (addr_valid && !hwrite) begin
         unique case (addr_idx)
            `IDX_STATE_WORD: next_st.rdata = {16'h0000, status};
            `IDX_CONTROL:    next_st.rdata = {23'h000000, st.ctrl};
            `IDX_IRQ_STATUS: next_st.rdata = {29'h00000000, st.flags};
            `IDX_IRQ_MASK:   next_st.rdata = {29'h00000000, st.mask};
            // write-only and unmapped words read zero
            default:         next_st.rdata = `WORD_ZERO;
         endcase
      end
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st.ctrl               <= `CONTROL_RESET;
         st.flags              <= `IRQ_BITS_RESET;
         st.mask               <= `IRQ_BITS_RESET;
         st.pin_meta           <= `PINS_RESET;
         st.pin_sync           <= `PINS_RESET;
         st.cnt3_prev          <= 1'b1;
         st.active_dma_channel <= 1'b0;
         st.wr_pend            <= 1'b0;
         st.wr_idx             <= 8'h00;
         st.rdata              <= `WORD_ZERO;
         st.irq                <= 1'b0;
         st.counter_one_gate   <= 1'b0;
         st.counter_two_gate   <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // ports straight from flip-flops; zero wait states, always okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   assign hrdata             = st.rdata;
   assign irq                = st.irq;
   assign active_dma_channel = st.active_dma_channel;
   assign counter_one_gate   = st.counter_one_gate;
   assign counter_two_gate   = st.counter_two_gate;

   // checks beside the logic

   AST_STATE_READ_LIVE: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (addr_valid && !hwrite && addr_idx == `IDX_STATE_WORD)
      |=> (hrdata[`BIT_G1_REQ] == $past(st.pin_sync.group1_request_line)) &&
          (hrdata[`BIT_G1_ACK] == $past(st.pin_sync.group1_acknowledge_line)) &&
          (hrdata[31:16] == 16'h0000))
      else $error("state word group 1 lines wrong");

   AST_STATE_READ_G2: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (addr_valid && !hwrite && addr_idx == `IDX_STATE_WORD)
      |=> (hrdata[`BIT_G2_REQ] == $past(st.pin_sync.group2_request_line)) &&
          (hrdata[`BIT_G2_ACK] == $past(st.pin_sync.group2_acknowledge_line)) &&
          !hrdata[`BIT_SPARE_HI] && !hrdata[`BIT_SPARE_LO])
      else $error("state word group 2 lines or spare bits wrong");

   AST_WIDE_READ: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (addr_valid && !hwrite && addr_idx == `IDX_STATE_WORD)
      |=> hrdata[`BIT_WIDE] == $past(st.ctrl.g1_wide && st.ctrl.g2_wide))
      else $error("wide transfer bit wrong");

   AST_CNT_SET: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (cnt3_rise && st.mask.counter) |=> st.flags.counter && irq)
      else $error("counter flag or irq not raised");

   AST_CNT_CLEAR: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (addr_valid && hwrite && addr_idx == `IDX_CNT_IRQ_CLR)
      ##1 !(cnt3_rise && st.mask.counter) |=> !st.flags.counter)
      else $error("counter flag not cleared");

   AST_TC1_CYCLE: assert property (
      @(posedge hclk) disable iff (!hresetn)
      group1_terminal_count ##1 (clr_tc1 && !group1_terminal_count)
      |-> st.flags.tc1 ##1 !st.flags.tc1)
      else $error("group 1 count flag set or clear wrong");

   AST_TC2_CYCLE: assert property (
      @(posedge hclk) disable iff (!hresetn)
      group2_terminal_count ##1 (clr_tc2 && !group2_terminal_count)
      |-> st.flags.tc2 ##1 !st.flags.tc2)
      else $error("group 2 count flag set or clear wrong");

   AST_TC_HOLD: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (st.flags.tc1 && !clr_tc1 && !w1c[1]) |=> st.flags.tc1)
      else $error("group 1 count flag lost");

   AST_TC2_HOLD: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (st.flags.tc2 && !clr_tc2 && !w1c[2]) |=> st.flags.tc2)
      else $error("group 2 count flag lost");

   AST_CHAN_ALTERNATE: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (st.ctrl.double_dma_mode && group1_dma_done)
      |=> active_dma_channel != $past(active_dma_channel))
      else $error("dma channel did not alternate");

   AST_CHAN_SINGLE: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !st.ctrl.double_dma_mode |=> !active_dma_channel)
      else $error("channel bit set outside double mode");

   AST_GATE_ONE: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (st.ctrl.counter_one_enable && !st.pin_sync.extra_input_one) |=> !counter_one_gate)
      else $error("counter one not gated by extra input");

   AST_GATE_TWO: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (st.ctrl.counter_two_enable && st.pin_sync.extra_input_two) |=> counter_two_gate)
      else $error("counter two gate not open");

   AST_IRQ_ORED: assert property (
      @(posedge hclk) disable iff (!hresetn)
      irq == |(st.flags & st.mask))
      else $error("irq disagrees with enabled flags");

   AST_READY_G1: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (!st.ctrl.g1_write_mode && !st.ctrl.g1_handshake_en) |-> !status[`BIT_G1_READY])
      else $error("group 1 ready without handshake");

   AST_READY_G2: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (st.ctrl.g2_write_mode && st.pin_sync.group2_request_line) |-> status[`BIT_G2_READY])
      else $error("group 2 ready missing in write mode");

   AST_REVISION: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (addr_valid && !hwrite && addr_idx == `IDX_STATE_WORD)
      |=> hrdata[`BIT_REVISION] == REVISION_ID)
      else $error("revision bit wrong");

   AST_BUS_READY: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (addr_valid && hwrite && addr_idx == `IDX_STATE_WORD)
      |=> hreadyout && !hresp ##1 $stable(st.ctrl) || !st.wr_pend)
      else $error("state word write disturbed the slave");

   AST_READ_DATA_DROP: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !(addr_valid && !hwrite) |=> hrdata == `WORD_ZERO)
      else $error("read data left standing after data phase");

   AST_CTRL_WRITE: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (st.wr_pend && st.wr_idx == `IDX_CONTROL) |=> st.ctrl == $past(hwdata[8:0]))
      else $error("control word write lost");

   AST_W1C_TC1: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (w1c[1] && !group1_terminal_count) |=> !st.flags.tc1)
      else $error("group 1 count flag not cleared by one");

   AST_W1C_CNT: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (w1c[0] && !(cnt3_rise && st.mask.counter)) |=> !st.flags.counter)
      else $error("counter flag not cleared by one");

   AST_STATE_READ_FLAGS: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (addr_valid && !hwrite && addr_idx == `IDX_STATE_WORD)
      |=> (hrdata[`BIT_TC1] == $past(st.flags.tc1)) &&
          (hrdata[`BIT_TC2] == $past(st.flags.tc2)) &&
          (hrdata[`BIT_CNT_IRQ] == $past(st.flags.counter)) &&
          (hrdata[`BIT_ACTIVE_CHAN] == $past(st.active_dma_channel)))
      else $error("state word flags or channel wrong");

   AST_EXTRA_READ: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (addr_valid && !hwrite && addr_idx == `IDX_STATE_WORD)
      |=> (hrdata[`BIT_EXTRA_ONE] == $past(st.pin_sync.extra_input_one)) &&
          (hrdata[`BIT_EXTRA_TWO] == $past(st.pin_sync.extra_input_two)))
      else $error("state word extra inputs wrong");

   AST_GATE_ONE_OPEN: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (st.ctrl.counter_one_enable && st.pin_sync.extra_input_one) |=> counter_one_gate)
      else $error("counter one gate not open");

   AST_GATE_OFF: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (!st.ctrl.counter_one_enable && !st.ctrl.counter_two_enable)
      |=> !counter_one_gate && !counter_two_gate)
      else $error("counter gate open without enable");

   AST_CHAN_HOLD: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (st.ctrl.double_dma_mode && !group1_dma_done)
      |=> active_dma_channel == $past(active_dma_channel))
      else $error("dma channel moved without a transfer");

   AST_TC1_SET: assert property (
      @(posedge hclk) disable iff (!hresetn)
      group1_terminal_count |=> st.flags.tc1)
      else $error("group 1 count flag not set");

   AST_TC2_SET: assert property (
      @(posedge hclk) disable iff (!hresetn)
      group2_terminal_count |=> st.flags.tc2)
      else $error("group 2 count flag not set");

endmodule : handshake_status_irq_clear

// ==== conn_device.sv ====
// model of the external handshaking device on the connector
module conn_device
   import hs_status_pkg::*;
(
   // clock that paces a slow device
   input  wire logic       hclk,
   // levels wanted, and which lines are actively driven
   input  wire conn_pins_t want,
   input  wire conn_pins_t drive,
   input  wire logic       slow,
   // lines as seen at the connector
   output conn_pins_t      pins
);
   timeunit 1ns;
   timeprecision 1ns;

   conn_pins_t held;   // slow device answers one clock late

   // a slow device only moves its lines after a clock
   always_ff @(posedge hclk) begin
      held <= want;
   end

   // released lines pulled up
   // a released line floats to the pull-up level, never to the last value
   assign pins = conn_pins_t'((slow ? held : want) | ~drive);
endmodule : conn_device

// ==== handshake_status_irq_clear_tb.sv ====
`include "hs_status_params.svh"
module handshake_status_irq_clear_tb import hs_status_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;

   localparam logic REV = 1'b1;   // arbitrary revision value
   // clock, reset and ahb-lite bus
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   // dma events and block outputs
   logic tc1, tc2, dma_done, gate1, gate2, chan, irq, slow;
   conn_pins_t want, drive, pins;   // connector stimulus and lines
   int n_fail, n_checks, cycles;
   int pos[6] = '{7, 6, 1, 0, 11, 5};   // status bit of each pin

   handshake_status_irq_clear #(.REVISION_ID(REV)) dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conn_pins(pins),
      .group1_terminal_count(tc1), .group2_terminal_count(tc2),
      .group1_dma_done(dma_done), .counter_one_gate(gate1),
      .counter_two_gate(gate2), .active_dma_channel(chan), .irq(irq));

   conn_device far_u (.hclk(hclk), .want(want), .drive(drive), .slow(slow), .pins(pins));

   // free-running bus clock
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   // prints the counts and the verdict, then stops
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict

   // a hang counts as a mismatch
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 4000) begin
         n_fail++;
         give_verdict();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   // one single transfer; address held until hready, data taken at the next hready
   task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {22'h0, idx, 2'b00};
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
      logic [31:0] d;
      bus(idx, 1'b1, wd, d);
   endtask : wr

   // read a word and compare the masked bits
   task automatic rdc(input string what, input logic [7:0] idx, input logic [31:0] m,
                      input logic [31:0] exp);
      logic [31:0] d;
      bus(idx, 1'b0, 32'h0, d);
      chk(what, exp, d & m);
   endtask : rdc

   // one-cycle pulse on {dma_done, tc2, tc1}
   task automatic pulse(input logic [2:0] ev);
      @(posedge hclk);
      {dma_done, tc2, tc1} <= ev;
      @(posedge hclk);
      {dma_done, tc2, tc1} <= 3'h0;
   endtask : pulse

   // drop then raise counter 3 output, letting the synchroniser follow
   task automatic cnt3_rise();
      want.cnt3_out <= 1'b0;
      repeat (5) @(posedge hclk);
      want.cnt3_out <= 1'b1;
      repeat (5) @(posedge hclk);
   endtask : cnt3_rise

   initial begin
      {hsel, hwrite, tc1, tc2, dma_done, slow} = 6'h00;
      {haddr, hwdata, htrans} = 66'h0;
      want = conn_pins_t'(7'h00);
      drive = conn_pins_t'(7'h00);   // all released, pull-ups win
      hresetn = 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      rdc("state after reset", `IDX_STATE_WORD, 32'hFFFF_FFFF, {27'h0, REV, 4'h0} | 32'h08E3);
      chk("irq after reset", 32'h0, {31'h0, irq});
      $display("test reset done");
      // live lines, prompt and slow device in turn
      drive <= conn_pins_t'(7'h7F);
      for (int i = 0; i < 6; i++) begin
         slow <= i[0];
         want <= conn_pins_t'(7'h7F & ~(7'h01 << i));
         repeat (5) @(posedge hclk);
         rdc("live line", `IDX_STATE_WORD, 32'h08E3, 32'h08E3 & ~(32'h1 << pos[i]));
      end
      want <= conn_pins_t'(7'h7F);
      slow <= 1'b0;
      $display("test lines done");
      // ready bits by mode, wide flag, counter gates
      wr(`IDX_CONTROL, 32'h120);
      rdc("ready both", `IDX_STATE_WORD, 32'h0104, 32'h0104);
      want.group1_request_line <= 1'b0;
      repeat (4) @(posedge hclk);
      rdc("ready g1 low", `IDX_STATE_WORD, 32'h0104, 32'h0004);
      want.group1_request_line <= 1'b1;
      wr(`IDX_CONTROL, 32'h002);
      rdc("read mode no handshake", `IDX_STATE_WORD, 32'h1104, 32'h0);
      wr(`IDX_CONTROL, 32'h01E);
      rdc("both wide", `IDX_STATE_WORD, 32'h1000, 32'h1000);
      chk("gates on", 32'h3, {30'h0, gate2, gate1});
      want.extra_input_one <= 1'b0;
      repeat (5) @(posedge hclk);
      chk("gate one held off", 32'h2, {30'h0, gate2, gate1});
      want.extra_input_one <= 1'b1;
      $display("test modes done");
      // terminal count flags of both groups
      for (int k = 0; k < 2; k++) begin
         wr(`IDX_IRQ_MASK, 32'h0);
         pulse(k ? 3'h2 : 3'h1);
         rdc("tc latched", `IDX_STATE_WORD, 32'h0600, 32'h0200 << k);
         chk("tc masked", 32'h0, {31'h0, irq});
         wr(`IDX_IRQ_MASK, 32'h2 << k);
         // irq is registered on the same edge that the mask lands
         @(posedge hclk);
         chk("tc pending", 32'h1, {31'h0, irq});
         wr(k ? `IDX_TC1_CLR : `IDX_TC2_CLR, 32'h0);
         rdc("other clear", `IDX_STATE_WORD, 32'h0600, 32'h0200 << k);
         wr(k ? `IDX_TC2_CLR : `IDX_TC1_CLR, 32'hFFFF_FFFF);
         rdc("tc cleared", `IDX_STATE_WORD, 32'h0600, 32'h0);
         chk("tc irq gone", 32'h0, {31'h0, irq});
      end
      // a clear that follows a count, then a count in the clearing cycle
      fork
         wr(`IDX_TC1_CLR, 32'h0);
         pulse(3'h1);
      join
      rdc("clear after count", `IDX_STATE_WORD, 32'h0200, 32'h0);
      fork
         wr(`IDX_TC1_CLR, 32'h0);
         begin
            @(posedge hclk);
            pulse(3'h1);
         end
      join
      rdc("count beats clear", `IDX_STATE_WORD, 32'h0200, 32'h0200);
      wr(`IDX_TC1_CLR, 32'h0);
      rdc("count cleared again", `IDX_STATE_WORD, 32'h0200, 32'h0);
      $display("test terminal count done");
      // counter 3 flag needs its enable
      wr(`IDX_IRQ_MASK, 32'h0);
      cnt3_rise();
      rdc("counter disabled", `IDX_STATE_WORD, 32'h4000, 32'h0);
      wr(`IDX_IRQ_MASK, 32'h1);
      cnt3_rise();
      rdc("counter flag", `IDX_STATE_WORD, 32'h4000, 32'h4000);
      chk("counter irq", 32'h1, {31'h0, irq});
      wr(`IDX_CNT_IRQ_CLR, 32'h0);
      rdc("counter cleared", `IDX_STATE_WORD, 32'h4000, 32'h0);
      chk("counter irq gone", 32'h0, {31'h0, irq});
      $display("test counter done");
      // double dma alternation, then mode off
      wr(`IDX_CONTROL, 32'h001);
      rdc("first channel", `IDX_STATE_WORD, 32'h8000, 32'h0);
      pulse(3'h4);
      rdc("second channel", `IDX_STATE_WORD, 32'h8000, 32'h8000);
      chk("channel port", 32'h1, {31'h0, chan});
      pulse(3'h4);
      rdc("back to first", `IDX_STATE_WORD, 32'h8000, 32'h0);
      pulse(3'h4);
      wr(`IDX_CONTROL, 32'h000);
      rdc("single mode", `IDX_STATE_WORD, 32'h8000, 32'h0);
      $display("test double dma done");
      // own registers read back, flags cleared by writing ones
      wr(`IDX_CONTROL, 32'h1FE);
      rdc("control back", `IDX_CONTROL, 32'hFFFF_FFFF, 32'h1FE);
      wr(`IDX_CONTROL, 32'h000);
      wr(`IDX_IRQ_MASK, 32'h6);
      pulse(3'h3);
      rdc("flags back", `IDX_IRQ_STATUS, 32'hFFFF_FFFF, 32'h6);
      rdc("mask back", `IDX_IRQ_MASK, 32'hFFFF_FFFF, 32'h6);
      wr(`IDX_IRQ_STATUS, 32'h2);
      rdc("one clears tc1", `IDX_STATE_WORD, 32'h0600, 32'h0400);
      chk("tc2 irq stays", 32'h1, {31'h0, irq});
      wr(`IDX_IRQ_STATUS, 32'h4);
      rdc("one clears tc2", `IDX_STATE_WORD, 32'h0600, 32'h0);
      chk("irq after one clears", 32'h0, {31'h0, irq});
      // read-only word, spare bits, unmapped place
      wr(`IDX_STATE_WORD, 32'hFFFF_FFFF);
      rdc("upper and spare", `IDX_STATE_WORD, 32'hFFFF_2008, 32'h0);
      rdc("unmapped", 8'h3F, 32'hFFFF_FFFF, 32'h0);
      chk("response", 32'h0, {31'h0, hresp});
      $display("test map done");
      give_verdict();
   end
endmodule : handshake_status_irq_clear_tb
